// File: logic/rpmc_pkg.sv
// package: constants and types for the radio power mode and channel control block
package rpmc_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CTRL_OFS     = 8'h00; // config flag word, busy, tx power
   localparam logic [7:0] REG_CHAN_OFS     = 8'h04; // requested channel
   localparam logic [7:0] REG_INTERVAL_OFS = 8'h08; // listen prescaler
   localparam logic [7:0] REG_COUNT_OFS    = 8'h0c; // countdown cycles
   localparam logic [7:0] REG_WINDOW_OFS   = 8'h10; // listen window length, ms
   localparam logic [7:0] REG_STATUS_OFS   = 8'h14; // state and enables
   localparam logic [7:0] REG_FREQ_OFS     = 8'h18; // channel in use and carrier
   // field positions
   localparam int CFG_PIN_IGNORE_BIT = 3;
   localparam int CTRL_BUSY_BIT      = 16;
   localparam int CTRL_PWR_LSB       = 24;
   // reset values
   localparam logic [15:0] CFG_FLAGS_RST   = 16'h0000;
   localparam logic [7:0]  CHAN_RST        = 8'h6a;   // channel 106
   localparam logic [7:0]  TX_POWER_RST    = 8'h07;   // 7 dBm
   localparam logic [15:0] PRESCALER_RST   = 16'h1000;
   localparam logic [15:0] COUNTDOWN_RST   = 16'h0001;
   localparam logic [15:0] WINDOW_RST      = 16'h000a;
   // channel raster
   localparam logic [7:0]  CHAN_MIN        = 8'h67;   // 103
   localparam logic [7:0]  CHAN_MAX        = 8'h6d;   // 109
   localparam logic [7:0]  CHAN_BASE       = 8'h64;   // 100
   localparam int          BASE_FREQ_KHZ   = 868000;
   localparam int          SPACING_KHZ     = 50;
   // timing
   localparam int CLK_HZ        = 125000000;
   localparam int TICK_HZ       = 4096;
   localparam int TICK_CYCLES   = CLK_HZ / TICK_HZ;          // tick period a little short, rounds down
   localparam int MS_CYCLES     = CLK_HZ / 1000;
   localparam int WAKE_SETTLE   = 4;                         // cycles before ready
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_STANDBY,
      ST_LISTEN_SLEEP,
      ST_LISTEN_RX,
      ST_SLEEP,
      ST_WAKING
   } rpmc_state_t;
endpackage

// File: logic/rpmc_chan_map.sv
// channel clamp and carrier frequency computation
`timescale 1ns/1ps
module rpmc_chan_map
   import rpmc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  chan_req,
   output logic [7:0]       chan_used,
   output logic [19:0]      carrier_khz
);
   logic [7:0]  chan_d;
   logic [19:0] freq_d;

   // edge channels folded silently onto the nearest allowed one
   always_comb
   begin
      if (chan_req < CHAN_MIN)
         chan_d = CHAN_MIN;
      else if (chan_req > CHAN_MAX)
         chan_d = CHAN_MAX;
      else
         chan_d = chan_req;
      freq_d = 20'(BASE_FREQ_KHZ) + 20'(SPACING_KHZ) * 20'(chan_d - CHAN_BASE);
   end

   // registered so the result feeds straight to the frequency register readout
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         chan_used   <= CHAN_RST;
         carrier_khz <= 20'(BASE_FREQ_KHZ) + 20'(SPACING_KHZ) * 20'(CHAN_RST - CHAN_BASE);
      end
      else
      begin
         chan_used   <= chan_d;
         carrier_khz <= freq_d;
      end
   end
endmodule

// File: logic/rpmc_tick_div.sv
// divider giving one-cycle tick pulses
`timescale 1ns/1ps
module rpmc_tick_div #(
   parameter int DIV = 30517
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic run,
   output logic      tick
);
   logic [$clog2(DIV+1)-1:0] cnt_q;

   // restarts whenever run drops so each period is whole
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !run)
      begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end
      else if (cnt_q == ($clog2(DIV+1))'(DIV - 1))
      begin
         cnt_q <= '0;
         tick  <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 1'b1;
         tick  <= 1'b0;
      end
   end
endmodule

// File: logic/rpmc_top.sv
// power state and channel control with an AXI4-Lite register port
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rpmc_top
   import rpmc_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES,
   parameter int MS_DIV   = MS_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        sleep_input,
   input  wire logic        transceiver_off_input,
   input  wire logic        transfer_pending,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             flow_busy,
   output logic             rx_enable,
   output logic             tx_enable,
   output logic             uart_enable,
   output logic [7:0]       tx_power,
   output logic [7:0]       radio_channel
);
   rpmc_state_t state_q;
   logic [15:0] config_flag_word_q;
   logic [7:0]  chan_req_q;
   logic [15:0] prescaler_q;
   logic [15:0] countdown_q;
   logic [15:0] listen_window_length_q;
   logic [15:0] tick_cnt_q;
   logic [15:0] win_cnt_q;
   logic [2:0]  settle_q;
   logic        sleep_prev_q;
   logic        off_prev_q;
   logic [7:0]  aw_addr_q;
   logic        aw_have_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        w_have_q;
   logic [7:0]  chan_used;
   logic [19:0] carrier_khz;
   logic        tick_4k;
   logic        tick_ms;
   logic        pins_ignored;
   logic        sleep_lvl;
   logic        off_lvl;
   logic        pin_fall;
   logic        wr_fire;
   logic        in_listen;
   rpmc_state_t pin_state;

   // flag bit 3 makes the pins read as low, so the block stays active
   assign pins_ignored = config_flag_word_q[CFG_PIN_IGNORE_BIT];
   assign sleep_lvl    = sleep_input & ~pins_ignored;
   assign off_lvl      = transceiver_off_input & ~pins_ignored;
   assign pin_fall     = (sleep_prev_q & ~sleep_lvl) | (off_prev_q & ~off_lvl);
   assign in_listen    = (state_q == ST_LISTEN_SLEEP) || (state_q == ST_LISTEN_RX);

   // pin decode into the requested state; host keeps both levels defined
   always_comb
   begin
      case ({sleep_lvl, off_lvl})
         2'b00:   pin_state = ST_ACTIVE;
         2'b01:   pin_state = ST_STANDBY;
         2'b10:   pin_state = ST_LISTEN_SLEEP;
         default: pin_state = ST_SLEEP;
      endcase
   end

   rpmc_chan_map u_chan (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .chan_req    (chan_req_q),
      .chan_used   (chan_used),
      .carrier_khz (carrier_khz)
   );

   // 4096 Hz prescaler base, only running in ST_LISTEN_SLEEP
   rpmc_tick_div #(.DIV(TICK_DIV)) u_tick4k (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (state_q == ST_LISTEN_SLEEP),
      .tick    (tick_4k)
   );

   // millisecond base for the receive window
   rpmc_tick_div #(.DIV(MS_DIV)) u_tickms (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (state_q == ST_LISTEN_RX),
      .tick    (tick_ms)
   );

   // pin history for edge detection
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sleep_prev_q <= 1'b0;
         off_prev_q   <= 1'b0;
      end
      else
      begin
         sleep_prev_q <= sleep_lvl;
         off_prev_q   <= off_lvl;
      end
   end

   // power state machine
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q    <= ST_ACTIVE;
         tick_cnt_q <= '0;
         win_cnt_q  <= '0;
         settle_q   <= '0;
      end
      else
      begin
         case (state_q)
            ST_ACTIVE:
               // pending work holds us in active mode
               if (pin_state != ST_ACTIVE && !transfer_pending && !flow_busy)
               begin
                  state_q    <= pin_state;
                  tick_cnt_q <= '0;
               end
            ST_STANDBY:
               if (pin_state != ST_STANDBY)
               begin
                  state_q    <= (pin_state == ST_SLEEP) ? ST_SLEEP : pin_state;
                  tick_cnt_q <= '0;
               end
            ST_LISTEN_SLEEP:
               if (pin_state != ST_LISTEN_SLEEP)
                  state_q <= (pin_state == ST_SLEEP) ? ST_SLEEP : ST_WAKING;
               else if (tick_4k)
               begin
                  // countdown times prescaler ticks of 1/4096 s
                  if (tick_cnt_q + 16'h0001 >= 16'(32'(countdown_q) * 32'(prescaler_q) > 32'h0000ffff
                      ? 16'hffff : countdown_q * prescaler_q))
                  begin
                     tick_cnt_q <= '0;
                     win_cnt_q  <= '0;
                     state_q    <= ST_LISTEN_RX;
                  end
                  else
                     tick_cnt_q <= tick_cnt_q + 16'h0001;
               end
            ST_LISTEN_RX:
               if (pin_state != ST_LISTEN_SLEEP)
                  state_q <= (pin_state == ST_SLEEP) ? ST_SLEEP : ST_WAKING;
               else if (tick_ms)
               begin
                  if (win_cnt_q + 16'h0001 >= listen_window_length_q)
                     state_q <= ST_LISTEN_SLEEP;
                  else
                     win_cnt_q <= win_cnt_q + 16'h0001;
               end
            ST_SLEEP:
               // only a falling edge wakes us, a plain level does not
               if (pin_fall)
               begin
                  state_q  <= ST_WAKING;
                  settle_q <= '0;
               end
            ST_WAKING:
               // settle and tick counters restart clean, whichever state led here
               if (settle_q == 3'(WAKE_SETTLE - 1))
               begin
                  state_q    <= pin_state;
                  settle_q   <= '0;
                  tick_cnt_q <= '0;
               end
               else
                  settle_q <= settle_q + 3'd1;
            default:
               state_q <= ST_ACTIVE;
         endcase
      end
   end

   // enables and flow-control flag, all registered
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_enable   <= 1'b0;
         tx_enable   <= 1'b0;
         uart_enable <= 1'b0;
         flow_busy   <= 1'b1;
      end
      else
      begin
         rx_enable   <= (state_q == ST_ACTIVE) || (state_q == ST_LISTEN_RX);
         tx_enable   <= (state_q == ST_ACTIVE) || (state_q == ST_STANDBY);
         uart_enable <= (state_q == ST_ACTIVE) || (state_q == ST_STANDBY) || in_listen;
         // high while asleep, mid-transition or with a transfer pending, low otherwise
         flow_busy   <= (state_q == ST_SLEEP) || (state_q == ST_WAKING) || transfer_pending;
      end
   end

   // AXI write: address and data taken in either order
   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         aw_addr_q     <= '0;
         w_data_q      <= '0;
         w_strb_q      <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_have_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_have_q <= 1'b0;
      end
   end

   // configuration registers and write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         config_flag_word_q     <= CFG_FLAGS_RST;
         chan_req_q             <= CHAN_RST;
         tx_power               <= TX_POWER_RST;
         prescaler_q            <= PRESCALER_RST;
         countdown_q            <= COUNTDOWN_RST;
         listen_window_length_q <= WINDOW_RST;
         s_axi_bvalid           <= 1'b0;
         s_axi_bresp            <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= RESP_OKAY;
            if (aw_addr_q == REG_CTRL_OFS)
            begin
               if (w_strb_q[0]) config_flag_word_q[7:0]  <= w_data_q[7:0];
               if (w_strb_q[1]) config_flag_word_q[15:8] <= w_data_q[15:8];
               if (w_strb_q[3]) tx_power                 <= w_data_q[31:24];
            end
            else if (aw_addr_q == REG_CHAN_OFS)
            begin
               if (w_strb_q[0]) chan_req_q <= w_data_q[7:0];
            end
            else if (aw_addr_q == REG_INTERVAL_OFS)
            begin
               if (w_strb_q[0]) prescaler_q[7:0]  <= w_data_q[7:0];
               if (w_strb_q[1]) prescaler_q[15:8] <= w_data_q[15:8];
            end
            else if (aw_addr_q == REG_COUNT_OFS)
            begin
               if (w_strb_q[0]) countdown_q[7:0]  <= w_data_q[7:0];
               if (w_strb_q[1]) countdown_q[15:8] <= w_data_q[15:8];
            end
            else if (aw_addr_q == REG_WINDOW_OFS)
            begin
               if (w_strb_q[0]) listen_window_length_q[7:0]  <= w_data_q[7:0];
               if (w_strb_q[1]) listen_window_length_q[15:8] <= w_data_q[15:8];
            end
            else if (aw_addr_q == REG_STATUS_OFS || aw_addr_q == REG_FREQ_OFS)
               s_axi_bresp <= RESP_OKAY; // read-only, write dropped
            else
               s_axi_bresp <= RESP_SLVERR;
         end
      end
   end

   // read channel, one request at a time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            if (s_axi_araddr == REG_CTRL_OFS)
               s_axi_rdata <= {tx_power, 7'h00, flow_busy, config_flag_word_q};
            else if (s_axi_araddr == REG_CHAN_OFS)
               s_axi_rdata <= {24'h000000, chan_req_q};
            else if (s_axi_araddr == REG_INTERVAL_OFS)
               s_axi_rdata <= {16'h0000, prescaler_q};
            else if (s_axi_araddr == REG_COUNT_OFS)
               s_axi_rdata <= {16'h0000, countdown_q};
            else if (s_axi_araddr == REG_WINDOW_OFS)
               s_axi_rdata <= {16'h0000, listen_window_length_q};
            else if (s_axi_araddr == REG_STATUS_OFS)
               s_axi_rdata <= {25'h0000000, uart_enable, tx_enable, rx_enable, 1'b0, state_q};
            else if (s_axi_araddr == REG_FREQ_OFS)
               s_axi_rdata <= {4'h0, carrier_khz, chan_used};
            else
            begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         end
      end
   end

   // channel actually used goes out registered
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         radio_channel <= CHAN_RST;
      else
         radio_channel <= chan_used;
   end
endmodule

// File: tb/rpmc_top_asserts.sv
// checker: assertions on the mode, flow-control and channel ports of rpmc_top
`timescale 1ns/1ps
module rpmc_asserts
   import rpmc_pkg::*;
#(
   parameter int TICK_DIV = 4,
   parameter int MS_DIV   = 8
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        sleep_input,
   input wire logic        transceiver_off_input,
   input wire logic        transfer_pending,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        flow_busy,
   input wire logic        rx_enable,
   input wire logic        tx_enable,
   input wire logic        uart_enable,
   input wire logic [7:0]  radio_channel
);
   logic       ign_q;
   logic [7:0] ch_q;
   logic [7:0] wd;
   logic       w_hs;
   logic       act_o;
   logic       p_ac;
   logic       p_sb;
   logic       p_sl;
   logic       lst;
   // only seen when address and data are taken together, as the bench offers them
   assign w_hs  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
   assign wd    = s_axi_wdata[7:0];
   assign act_o = rx_enable && tx_enable && uart_enable;
   assign p_ac  = !sleep_input && !transceiver_off_input;
   assign p_sb  = !sleep_input && transceiver_off_input && !ign_q && !transfer_pending;
   assign p_sl  = sleep_input && transceiver_off_input && !ign_q && !transfer_pending;
   assign lst   = sleep_input && !transceiver_off_input && !ign_q;
   // shadow of the pin-ignore flag and of the clamped channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ign_q <= 1'b0;
         ch_q  <= CHAN_RST;
      end
      else if (w_hs && s_axi_awaddr == REG_CTRL_OFS)
         ign_q <= s_axi_wdata[CFG_PIN_IGNORE_BIT];
      else if (w_hs && s_axi_awaddr == REG_CHAN_OFS)
         ch_q <= (wd < CHAN_MIN) ? CHAN_MIN : ((wd > CHAN_MAX) ? CHAN_MAX : wd);
   end

   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_pend_active;
      transfer_pending ##1 act_o;
   endsequence
   sequence s_wake;
      flow_busy && !uart_enable && $fell(sleep_input);
   endsequence

   active_pins_a : assert property (p_ac[*8] |=> act_o)
      else $error("enables off with both pins low");
   standby_pins_a : assert property (p_sb[*8] |=> !rx_enable && tx_enable && uart_enable)
      else $error("standby enables wrong");
   sleep_pins_a : assert property (p_sl[*8] |=> !act_o && !rx_enable && !uart_enable && flow_busy)
      else $error("sleep outputs wrong");
   pend_hold_a : assert property (s_pend_active |-> flow_busy ##1 act_o)
      else $error("left active with a transfer pending");
   wake_ready_a : assert property (s_wake |-> ##[1:10] (uart_enable && !flow_busy))
      else $error("no wake after pin fall");
   wake_ack_a : assert property (s_wake |=> flow_busy[*3])
      else $error("busy dropped during wake");
   listen_win_a : assert property (lst && $rose(rx_enable) |-> ##[1:1000] (!rx_enable || !lst))
      else $error("listen window never closed");
   chan_write_a : assert property (w_hs && s_axi_awaddr == REG_CHAN_OFS |-> ##[2:6] radio_channel == ch_q)
      else $error("channel not clamped");
endmodule

bind rpmc_top rpmc_asserts #(.TICK_DIV(TICK_DIV), .MS_DIV(MS_DIV)) i_rpmc_asserts (
   .aclk, .aresetn, .sleep_input, .transceiver_off_input, .transfer_pending, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
   .flow_busy, .rx_enable, .tx_enable, .uart_enable, .radio_channel);

// File: tb/rpmc_host_model.sv
// host model: drives the mode pins and bursts of pending transfers
`timescale 1ns/1ps
module rpmc_host_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [1:0] pins_cmd,
   input  wire logic [7:0] xfer_len,
   input  wire logic       xfer_go,
   input  wire logic       flow_busy,
   output logic            sleep_input,
   output logic            transceiver_off_input,
   output logic            transfer_pending
);
   logic [7:0] left_q = 8'h00;
   logic       want_q = 1'b0;
   // pins always held at a defined level, never floated
   assign sleep_input           = pins_cmd[1];
   assign transceiver_off_input = pins_cmd[0];
   assign transfer_pending      = left_q != 8'h00;
   // a burst waits for the ready level and has a bounded length, keeping air time low
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         left_q <= 8'h00;
         want_q <= 1'b0;
      end
      else if (want_q && !flow_busy)
      begin
         left_q <= xfer_len;
         want_q <= 1'b0;
      end
      else
      begin
         want_q <= want_q || xfer_go;
         left_q <= left_q - {7'h00, transfer_pending};
      end
   end
endmodule

// File: tb/tb_top.sv
// testbench: register access, pin modes, channel clamp and listen timing
`timescale 1ns/1ps
module tb_top;
   import rpmc_pkg::*;
   localparam int TDIV = 4;
   localparam int MDIV = 8;
   logic        aclk          = 1'b0;
   logic        aresetn       = 1'b0;
   logic [7:0]  s_axi_awaddr  = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata   = 32'h0;
   logic [3:0]  s_axi_wstrb   = 4'h0;
   logic        s_axi_wvalid  = 1'b0;
   logic        s_axi_bready  = 1'b0;
   logic [7:0]  s_axi_araddr  = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready  = 1'b0;
   logic [1:0]  pins_cmd      = 2'h0;
   logic [7:0]  xfer_len      = 8'h00;
   logic        xfer_go       = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rdat;
   logic        flow_busy, rx_enable, tx_enable, uart_enable;
   logic        sleep_input, transceiver_off_input, transfer_pending;
   logic [7:0]  tx_power, radio_channel;
   int          fails = 0, compares = 0, cyc = 0, n = 0;
   logic [7:0]  ofs [5] = '{REG_CTRL_OFS, REG_CHAN_OFS, REG_INTERVAL_OFS, REG_COUNT_OFS, REG_WINDOW_OFS};
   logic [31:0] rst [5] = '{32'h0700_0000, 32'h6a, 32'h1000, 32'h1, 32'ha};
   logic [7:0]  chs [7] = '{8'h00, 8'h66, 8'h67, 8'h6d, 8'h6e, 8'hff, 8'h6a};
   logic [1:0]  mp [6]  = '{2'h1, 2'h3, 2'h0, 2'h3, 2'h1, 2'h0};
   logic [7:0]  ms [6]  = '{8'h61, 8'h04, 8'h70, 8'h04, 8'h61, 8'h70};

   rpmc_top #(.TICK_DIV(TDIV), .MS_DIV(MDIV)) i_rpmc_top (
      .aclk, .aresetn, .sleep_input, .transceiver_off_input, .transfer_pending,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flow_busy,
      .rx_enable, .tx_enable, .uart_enable, .tx_power, .radio_channel);
   rpmc_host_model i_rpmc_host_model (
      .aclk, .aresetn, .pins_cmd, .xfer_len, .xfer_go, .flow_busy,
      .sleep_input, .transceiver_off_input, .transfer_pending);

   always #4 aclk = ~aclk;

   // expected frequency-word view of a channel request: carrier in kHz over the clamped channel
   function automatic logic [31:0] freqw(input logic [7:0] c);
      logic [7:0] k;
      k = (c < CHAN_MIN) ? CHAN_MIN : ((c > CHAN_MAX) ? CHAN_MAX : c);
      return {4'h0, 20'(BASE_FREQ_KHZ + SPACING_KHZ * (int'(k) - int'(CHAN_BASE))), k};
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // write: address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axr(input logic [7:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic set_pins(input logic [1:0] p);
      pins_cmd <= p;
      repeat (16) @(posedge aclk);
   endtask

   // counts edges until rx_enable shows the wanted level
   task automatic wait_rx(input logic v);
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (rx_enable !== v);
   endtask

   task automatic conclude();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // hang guard, well above the few hundred cycles the sequence needs
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         conclude();
      end
   end

   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(tx_power, 32'h7);
      for (int i = 0; i < 5; i++)
      begin
         axr(ofs[i]);
         chk(rdat, rst[i]);
         chk(resp, RESP_OKAY);
      end
      axr(8'h1c);
      chk(resp, RESP_SLVERR);
      chk(rdat, 32'h0);
      axw(8'h1c, 32'h1, 4'hf);
      chk(resp, RESP_SLVERR);
      axw(REG_STATUS_OFS, 32'hffff_ffff, 4'hf);
      chk(resp, RESP_OKAY);
      // requests below, at and above the range, then back to a channel usable at every rate
      for (int i = 0; i < 7; i++)
      begin
         axw(REG_CHAN_OFS, {24'h0, chs[i]}, 4'hf);
         axr(REG_FREQ_OFS);
         chk(rdat, freqw(chs[i]));
         chk(radio_channel, freqw(chs[i]) & 32'hff);
      end
      for (int i = 0; i < 6; i++)
      begin
         set_pins(mp[i]);
         axr(REG_STATUS_OFS);
         chk(rdat, {24'h0, ms[i]});
         chk({flow_busy, uart_enable, tx_enable, rx_enable}, {ms[i][2], ms[i][6:4]});
      end
      // sleep requested while a transfer is still outstanding
      xfer_len <= 8'd40;
      xfer_go  <= 1'b1;
      @(posedge aclk);
      xfer_go  <= 1'b0;
      while (transfer_pending !== 1'b1)
         @(posedge aclk);
      set_pins(2'h3);
      chk({flow_busy, uart_enable, tx_enable, rx_enable}, 4'hf);
      while (transfer_pending !== 1'b0)
         @(posedge aclk);
      set_pins(2'h3);
      chk({flow_busy, uart_enable, tx_enable, rx_enable}, 4'h8);
      // lane 0 only, so the power field must survive
      axw(REG_CTRL_OFS, 32'h8, 4'h1);
      set_pins(2'h3);
      chk({flow_busy, uart_enable, tx_enable, rx_enable}, 4'h7);
      axr(REG_CTRL_OFS);
      chk(rdat, 32'h0700_0008);
      axw(REG_CTRL_OFS, 32'h0, 4'h1);
      set_pins(2'h3);
      chk({flow_busy, uart_enable, tx_enable, rx_enable}, 4'h8);
      axw(REG_INTERVAL_OFS, 32'h2, 4'h3);
      axw(REG_COUNT_OFS, 32'h3, 4'h3);
      axw(REG_WINDOW_OFS, 32'h2, 4'h3);
      pins_cmd <= 2'h2;
      wait_rx(1'b1);
      wait_rx(1'b0);
      chk(n >= 2 * MDIV - 1 && n <= 2 * MDIV + 1, 32'h1);
      wait_rx(1'b1);
      chk(n >= 6 * TDIV && n <= 7 * TDIV, 32'h1);
      set_pins(2'h0);
      chk({flow_busy, uart_enable, tx_enable, rx_enable}, 4'h7);
      // power lane alone, raised after the end system is qualified
      axw(REG_CTRL_OFS, 32'h0e00_0000, 4'h8);
      chk(tx_power, 32'he);
      conclude();
   end
endmodule
